// ---- inc/csil_pkg.sv ----
// Package of the clock status and interrupt logic: register indexes,
// field positions, reset values and APB decode constants.
// Assumes a 32-bit APB bus where each register index takes one word.
package csil_pkg;
   // Register indexes; the byte address is four times the index
   localparam logic [7:0] IDX_IRQ_EN_LOCK_INPUTS = 8'h68;
   localparam logic [7:0] IDX_IRQ_EN_REF_HOLDOVER = 8'h69;
   localparam logic [7:0] IDX_STICKY_LOCK_INPUT_FLAGS = 8'h6c;
   localparam logic [7:0] IDX_LIVE_SELECT_LOCK_INPUTS = 8'h6d;
   localparam logic [7:0] IDX_STICKY_REF_HOLDOVER_FLAGS = 8'h6e;
   localparam logic [7:0] IDX_LIVE_CAL_REF_HOLDOVER = 8'h6f;

   // Field positions
   localparam int POS_PRIMARY = 5;
   localparam int POS_OSC = 4;
   localparam int POS_INPUT_MSB = 3;
   localparam int POS_SELECT_LSB = 6;
   localparam int POS_REFERENCE = 1;
   localparam int POS_HOLDOVER = 0;
   localparam int POS_CALIBRATING = 2;

   // Reset values
   localparam logic [5:0] RST_IRQ_EN_LOCK_INPUTS = 6'h00;
   localparam logic [1:0] RST_IRQ_EN_REF_HOLDOVER = 2'h0;
   localparam logic RST_PENDING = 1'b0;
   localparam logic RST_IRQ_OUT_N = 1'b1;

   // Synchroniser layout of the live inputs
   localparam int LIVE_W = 11;
   localparam logic [LIVE_W-1:0] RST_LIVE = 11'h000;

   localparam int APB_ADDR_W = 12;
   localparam logic [31:0] APB_READ_ZERO = 32'h0000_0000;
endpackage

// ---- src/csil_top.sv ----
// Status and interrupt logic of a dual-loop clock generator, with an APB slave.
// Assumes the live loop, input and selection indicators come from other
// clock domains and are synchronised here; the host services irq_out_n.
//
// Contract
// - Primary-loop unlock enable lets its sticky flag pull the interrupt low.
// - Oscillator-loop unlock enable lets its sticky flag pull the interrupt low.
// - Four per-input loss enables gate each input's sticky loss flag.
// - Reference enable raises interrupt on any change of the reference flag.
// - Holdover enable lets the sticky holdover flag pull the interrupt low.
// - Primary-loop unlock sticky reads 0 after any event; write 1 clears.
// - Oscillator-loop unlock sticky reads 0 after any event; write 1 clears.
// - Each input loss sticky reads 0 after any loss; write 1 clears.
// - Reference sticky reads 0 if reference lost since clear; write 1 clears.
// - Holdover sticky reads 0 if holdover entered since clear; write 1 clears.
// - Read-only two-bit field reports the selected input number.
// - Live active-high lock indicators for both loops.
// - Four live input activity bits, 0 while signal is lost.
// - Live holdover bit reads 0 while the oscillator loop is in holdover.
// - Live reference bit shows reference presence and feeds its sticky flag.
// - Live calibration bit reads 1 while calibration still runs.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps

module csil_top
   import csil_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [csil_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Live status from the loops, detectors and selector
   input wire logic [1:0] selected_input,
   input wire logic primary_loop_locked_live,
   input wire logic osc_loop_locked_live,
   input wire logic [3:0] input_active_live,
   input wire logic reference_present_live,
   input wire logic not_holdover_live,
   input wire logic loop_calibrating_live,
   // Interrupt
   output logic irq_out_n
);
   import csil_pkg::*;

   typedef struct packed {
      logic [LIVE_W-1:0] sync1;
      logic [LIVE_W-1:0] sync2;
      logic [LIVE_W-1:0] sync3;
      logic [LIVE_W-1:0] live;
      logic primary_loop_unlock_irq_en;
      logic osc_loop_unlock_irq_en;
      logic [3:0] input_loss_irq_en;
      logic reference_irq_en;
      logic holdover_irq_en;
      logic primary_pending;
      logic osc_pending;
      logic [3:0] input_pending;
      logic reference_lost;
      logic reference_changed;
      logic holdover_pending;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_out_n;
   } csil_state_t;

   csil_state_t state;
   csil_state_t next_state;

   // Live vector layout: {select[1:0], primary, osc, inputs[3:0], reference, not_holdover, calibrating}
   logic [LIVE_W-1:0] live_raw;
   assign live_raw = {selected_input, primary_loop_locked_live, osc_loop_locked_live,
                      input_active_live, reference_present_live, not_holdover_live,
                      loop_calibrating_live};

   logic [1:0] live_select;
   logic live_primary;
   logic live_osc;
   logic [3:0] live_inputs;
   logic live_reference;
   logic live_not_holdover;
   logic live_calibrating;
   assign {live_select, live_primary, live_osc, live_inputs, live_reference,
           live_not_holdover, live_calibrating} = state.live;

   // Decode
   logic [7:0] reg_index;
   logic addr_ok;
   logic [7:0] read_byte;
   logic access;
   logic commit;
   logic write_commit;

   assign access = psel & penable;
   assign commit = access & state.pready;
   assign write_commit = commit & pwrite & ~state.pslverr & pstrb[0];

   always_comb begin
      reg_index = paddr[9:2];
      addr_ok = (paddr[1:0] == 2'h0) && (paddr[APB_ADDR_W-1:10] == '0);
      read_byte = 8'h00;
      case (reg_index)
         IDX_IRQ_EN_LOCK_INPUTS: begin
            read_byte = {2'h0, state.primary_loop_unlock_irq_en, state.osc_loop_unlock_irq_en,
                         state.input_loss_irq_en};
         end
         IDX_IRQ_EN_REF_HOLDOVER: begin
            read_byte = {6'h00, state.reference_irq_en, state.holdover_irq_en};
         end
         IDX_STICKY_LOCK_INPUT_FLAGS: begin
            read_byte = {2'h0, ~state.primary_pending, ~state.osc_pending, ~state.input_pending};
         end
         IDX_LIVE_SELECT_LOCK_INPUTS: begin
            read_byte = {live_select, live_primary, live_osc, live_inputs};
         end
         IDX_STICKY_REF_HOLDOVER_FLAGS: begin
            read_byte = {6'h00, ~state.reference_lost, ~state.holdover_pending};
         end
         IDX_LIVE_CAL_REF_HOLDOVER: begin
            read_byte = {5'h00, live_calibrating, live_reference, live_not_holdover};
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   logic [7:0] wbyte;
   logic wr_en_lock;
   logic wr_en_ref;
   logic wr_clr_lock;
   logic wr_clr_ref;
   logic [LIVE_W-1:0] agree;
   logic [LIVE_W-1:0] live_new;
   logic irq_any;

   assign wbyte = pwdata[7:0];
   assign wr_en_lock = write_commit && reg_index == IDX_IRQ_EN_LOCK_INPUTS;
   assign wr_en_ref = write_commit && reg_index == IDX_IRQ_EN_REF_HOLDOVER;
   // Writing 0 to a sticky bit leaves it untouched
   assign wr_clr_lock = write_commit && reg_index == IDX_STICKY_LOCK_INPUT_FLAGS;
   assign wr_clr_ref = write_commit && reg_index == IDX_STICKY_REF_HOLDOVER_FLAGS;

   // A change counts only once the second and third stages agree
   assign agree = ~(state.sync2 ^ state.sync3);
   assign live_new = (state.sync3 & agree) | (state.live & ~agree);

   always_comb begin
      next_state = state;
      next_state.sync1 = live_raw;
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      next_state.live = live_new;

      if (wr_en_lock) begin
         next_state.primary_loop_unlock_irq_en = wbyte[POS_PRIMARY];
         next_state.osc_loop_unlock_irq_en = wbyte[POS_OSC];
         next_state.input_loss_irq_en = wbyte[POS_INPUT_MSB:0];
      end
      if (wr_en_ref) begin
         next_state.reference_irq_en = wbyte[POS_REFERENCE];
         next_state.holdover_irq_en = wbyte[POS_HOLDOVER];
      end

      // Set wins over clear, so an event in the clearing cycle is kept
      next_state.primary_pending = (state.primary_pending & ~(wr_clr_lock & wbyte[POS_PRIMARY]))
                                   | ~live_primary;
      next_state.osc_pending = (state.osc_pending & ~(wr_clr_lock & wbyte[POS_OSC]))
                               | ~live_osc;
      next_state.input_pending = (state.input_pending & ~({4{wr_clr_lock}} & wbyte[POS_INPUT_MSB:0]))
                                 | ~live_inputs;
      next_state.reference_lost = (state.reference_lost & ~(wr_clr_ref & wbyte[POS_REFERENCE]))
                                  | ~live_reference;
      // Reference interrupt fires on a change either way, loss or return
      next_state.reference_changed = (state.reference_changed & ~(wr_clr_ref & wbyte[POS_REFERENCE]))
                                     | (live_new[2] ^ live_reference);
      next_state.holdover_pending = (state.holdover_pending & ~(wr_clr_ref & wbyte[POS_HOLDOVER]))
                                    | ~live_not_holdover;

      // APB: one wait state, answer registered so outputs come from flops
      next_state.pready = access & ~state.pready;
      if (access & ~state.pready) begin
         next_state.pslverr = ~addr_ok;
         next_state.prdata = (addr_ok & ~pwrite) ? {24'h000000, read_byte} : APB_READ_ZERO;
      end else if (commit) begin
         next_state.pslverr = 1'b0;
         next_state.prdata = APB_READ_ZERO;
      end

      next_state.irq_out_n = ~irq_any;
   end

   // Uses current flags, so the pin follows a flag by one clock
   assign irq_any = (state.primary_loop_unlock_irq_en & state.primary_pending)
                    | (state.osc_loop_unlock_irq_en & state.osc_pending)
                    | (|(state.input_loss_irq_en & state.input_pending))
                    | (state.reference_irq_en & state.reference_changed)
                    | (state.holdover_irq_en & state.holdover_pending);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state.sync1 <= RST_LIVE;
         state.sync2 <= RST_LIVE;
         state.sync3 <= RST_LIVE;
         state.live <= RST_LIVE;
         state.primary_loop_unlock_irq_en <= RST_IRQ_EN_LOCK_INPUTS[POS_PRIMARY];
         state.osc_loop_unlock_irq_en <= RST_IRQ_EN_LOCK_INPUTS[POS_OSC];
         state.input_loss_irq_en <= RST_IRQ_EN_LOCK_INPUTS[POS_INPUT_MSB:0];
         state.reference_irq_en <= RST_IRQ_EN_REF_HOLDOVER[POS_REFERENCE];
         state.holdover_irq_en <= RST_IRQ_EN_REF_HOLDOVER[POS_HOLDOVER];
         state.primary_pending <= RST_PENDING;
         state.osc_pending <= RST_PENDING;
         state.input_pending <= {4{RST_PENDING}};
         state.reference_lost <= RST_PENDING;
         state.reference_changed <= RST_PENDING;
         state.holdover_pending <= RST_PENDING;
         state.prdata <= APB_READ_ZERO;
         state.pready <= 1'b0;
         state.pslverr <= 1'b0;
         state.irq_out_n <= RST_IRQ_OUT_N;
      end else begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign irq_out_n = state.irq_out_n;
endmodule

// ---- verif/csil_props.sv ----
// Port checker for csil_top: APB timing, readback and interrupt level.
// Assumes live inputs are held steady for several cycles before use.
`timescale 1ns/10ps
module csil_props
   import csil_pkg::*;
(
   // Clock, reset and APB (grouped to keep the checker short)
   input wire logic clock, arst_n, psel, penable, pwrite, pready, pslverr,
   input wire logic [csil_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   // Live status and interrupt
   input wire logic [1:0] selected_input,
   input wire logic primary_loop_locked_live, osc_loop_locked_live,
   input wire logic [3:0] input_active_live,
   input wire logic reference_present_live, not_holdover_live, loop_calibrating_live, irq_out_n
);
   typedef struct packed {logic [10:0] lv; logic [3:0] calm; logic [5:0] en68, e68; logic [1:0] en69, e69;} csil_chk_t;
   csil_chk_t st, next_st;
   logic [10:0] lv;
   logic rd, steady;
   assign lv = {selected_input, primary_loop_locked_live, osc_loop_locked_live, input_active_live,
      reference_present_live, not_holdover_live, loop_calibrating_live};
   assign rd = pready && !pwrite;
   // Synchroniser and sticky update need about six clocks; nine leaves margin
   assign steady = st.calm > 4'h8;
   always_comb begin
      next_st = st;
      next_st.lv = lv;
      next_st.calm = (lv != st.lv) ? 4'h0 : st.calm + 4'(st.calm != 4'hf);
      // Delayed copies line up with the pin, which follows enables one clock late
      next_st.e68 = st.en68;
      next_st.e69 = st.en69;
      if (pready && pwrite && pstrb[0] && paddr == 12'h1a0) next_st.en68 = pwdata[5:0];
      if (pready && pwrite && pstrb[0] && paddr == 12'h1a4) next_st.en69 = pwdata[1:0];
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) st <= '0;
      else st <= next_st;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
   a_wait: assert property (p_wait) else $error("pready not after one wait state");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
   property p_enrd; rd && paddr[11:3] == 9'h34 |-> prdata == (paddr[2] ? {30'h0, st.en69} : {26'h0, st.en68});
   endproperty
   a_enrd: assert property (p_enrd) else $error("enable readback wrong");
   property p_live6d; rd && steady && paddr == 12'h1b4 |-> prdata == {24'h0, lv[10:3]}; endproperty
   a_live6d: assert property (p_live6d) else $error("live select or lock read wrong");
   property p_live6f; rd && steady && paddr == 12'h1bc |-> prdata == {29'h0, lv[0], lv[2:1]}; endproperty
   a_live6f: assert property (p_live6f) else $error("live cal read wrong");
   property p_stk; rd && steady && paddr == 12'h1b0 |-> (prdata[5:0] & ~lv[8:3]) == 6'h0; endproperty
   a_stk: assert property (p_stk) else $error("lock or input sticky not set");
   property p_stk2; rd && steady && paddr == 12'h1b8 |-> (prdata[1:0] & ~lv[2:1]) == 2'h0; endproperty
   a_stk2: assert property (p_stk2) else $error("reference or holdover sticky not set");
   property p_irqlo; steady && ((st.e68 & ~lv[8:3]) != 6'h0 || (st.e69[0] && !lv[1])) |-> !irq_out_n;
   endproperty
   a_irqlo: assert property (p_irqlo) else $error("enabled event without interrupt");
   property p_irqhi; st.e68 == 6'h0 && st.e69 == 2'h0 |-> irq_out_n; endproperty
   a_irqhi: assert property (p_irqhi) else $error("interrupt with all enables off");
   c_err: cover property (pready && pslverr);
   c_irq: cover property (!irq_out_n);
   c_live: cover property (rd && steady && paddr == 12'h1b4);
endmodule
bind csil_top csil_props u_props (.*);

// ---- verif/csil_src_model.sv ----
// Far-side model: loops, loss detectors and selector driving the live status.
// Assumes the bench sets the wanted levels; the model holds them as levels.
`timescale 1ns/10ps
module csil_src_model (
   // Clock and wanted levels
   input wire logic clock,
   input wire logic [10:0] want,
   // Live status
   output logic [1:0] selected_input,
   output logic primary_loop_locked_live, osc_loop_locked_live,
   output logic [3:0] input_active_live,
   output logic reference_present_live, not_holdover_live, loop_calibrating_live
);
   always @(posedge clock) begin
      {selected_input, primary_loop_locked_live, osc_loop_locked_live, input_active_live,
         reference_present_live, not_holdover_live, loop_calibrating_live} <= want;
   end
endmodule

// ---- verif/tb.sv ----
// Bench for csil_top: APB tasks, live status model and one task per scenario.
// Assumes one wait state per transfer and about six clocks from live input to pin.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
   import csil_pkg::*;
   localparam logic [10:0] GOOD = 11'h7fe;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [10:0] want = GOOD;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, irq_out_n;
   logic [1:0] selected_input;
   logic primary_loop_locked_live, osc_loop_locked_live, reference_present_live, not_holdover_live;
   logic loop_calibrating_live;
   logic [3:0] input_active_live;
   int num_errors = 0;
   int checked = 0;
   always #5 clock = ~clock;
   csil_top DUT (.*);
   csil_src_model u_src (.*);
   task automatic conclude();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         conclude();
      end
   endtask
   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
      apb(idx, 1'b0, 8'h0);
      `CHK(nm, e, rd)
      `CHK("pslverr mapped", 1'b0, err)
   endtask
   task automatic t_reset();
      `CHK("irq_out_n", 1'b1, irq_out_n)
      rdchk("en_lock", IDX_IRQ_EN_LOCK_INPUTS, 32'h0);
      rdchk("en_ref", IDX_IRQ_EN_REF_HOLDOVER, 32'h0);
      apb(IDX_STICKY_LOCK_INPUT_FLAGS, 1'b1, 8'hff);
      apb(IDX_STICKY_REF_HOLDOVER_FLAGS, 1'b1, 8'hff);
      rdchk("stk_lock", IDX_STICKY_LOCK_INPUT_FLAGS, 32'h3f);
      rdchk("stk_ref", IDX_STICKY_REF_HOLDOVER_FLAGS, 32'h3);
      $display("t_reset done");
   endtask
   task automatic t_live();
      logic [10:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {i[1:0], i[0], ~i[0], 4'h1 << i, ~i[1], i[1], i[0]};
         want <= v;
         wt(9);
         // Read-only place: the write must not disturb the live view
         apb(IDX_LIVE_SELECT_LOCK_INPUTS, 1'b1, 8'hff);
         rdchk("live_sel", IDX_LIVE_SELECT_LOCK_INPUTS, {24'h0, v[10:3]});
         rdchk("live_cal", IDX_LIVE_CAL_REF_HOLDOVER, {29'h0, v[0], v[2:1]});
      end
      want <= GOOD;
      $display("t_live done");
   endtask
   task automatic t_event(input logic [7:0] ie, is, input int k, b);
      logic [7:0] m;
      logic [7:0] fl;
      m = 8'h1 << k;
      fl = (is == IDX_STICKY_LOCK_INPUT_FLAGS) ? 8'h3f : 8'h03;
      wt(9);
      apb(is, 1'b1, 8'hff);
      want[b] <= 1'b0;
      wt(9);
      `CHK("irq masked", 1'b1, irq_out_n)
      apb(ie, 1'b1, m);
      wt(2);
      `CHK("irq raised", 1'b0, irq_out_n)
      want[b] <= 1'b1;
      wt(9);
      rdchk("sticky", is, {24'h0, fl & ~m});
      apb(is, 1'b1, ~m);
      wt(2);
      `CHK("irq kept", 1'b0, irq_out_n)
      apb(is, 1'b1, m);
      wt(2);
      `CHK("irq cleared", 1'b1, irq_out_n)
      apb(ie, 1'b1, 8'h0);
      $display("t_event done");
   endtask
   task automatic t_bus();
      apb(8'h6a, 1'b0, 8'h0);
      `CHK("pslverr", 1'b1, err)
      `CHK("unmapped", 32'h0, rd)
      $display("t_bus done");
   endtask
   initial begin
      wt(6);
      arst_n <= 1'b1;
      wt(10);
      t_reset();
      t_live();
      for (int k = 0; k < 6; k++) t_event(IDX_IRQ_EN_LOCK_INPUTS, IDX_STICKY_LOCK_INPUT_FLAGS, k, k + 3);
      for (int k = 0; k < 2; k++) t_event(IDX_IRQ_EN_REF_HOLDOVER, IDX_STICKY_REF_HOLDOVER_FLAGS, k, k + 1);
      t_bus();
      conclude();
   end
endmodule
